/* src/plc_loop_config.v */
// Configuration bank for a dual-loop clock conditioner: the first loop
// reference divider and pump, oscillator, output and power controls,
// and the second loop doubler, filter and pump output controls.
// Assumes a host loads whole registers through the parallel load port,
// synchronous to CORE_CLK_I; the serial framing is decoded elsewhere.
// Operation
// R1: Reference divider ratio 1..4095, zero invalid
// R2: Pump code selects current; 000/001 reserved
// R3: Polarity 0 negative slope, 1 positive slope
// R4: Crystal amplifier on when bit set
// R5: Auxiliary output enable, resets disabled
// R6: Global output enable at b18, resets 1
// R7: Power-down overrides every other bit, pin; the filter, polarity and pump code flag outputs here do not follow it
// R8: Doubler bypasses second divider, resets 0
// R9: Host enables doubler only below 50 MHz
// R10: Third-pole resistor code, 101..111 invalid
// R11: Fourth-pole resistor code, 101..111 invalid
// R12: Capacitor code picks pair; 1100+ reserved
// R13: First pump high impedance when bit set
// R14: Second pump high impedance when bit set
// R15: Clocks need both pin and global enable
// R16: Host never writes reserved or invalid codes
`timescale 1ns/100ps
`default_nettype none
`include "plc_map.vh"

module plc_loop_config
(
    // Clock and reset
    input  wire        CORE_CLK_I,
    input  wire        NRST_I,
    // Register load port
    input  wire        REG_WR_I,
    input  wire [3:0]  REG_ADDR_I,
    input  wire [31:0] REG_DATA_I,
    output reg  [31:0] REG_RDATA_O,
    // Device pins
    input  wire        OUTPUT_ENABLE_PIN_I,
    // First loop
    output reg         FIRST_REF_TICK_O,
    output reg  [8:0]  FIRST_PUMP_CURRENT_O,
    output reg         FIRST_PUMP_CODE_OK_O,
    output reg         FIRST_PUMP_POLARITY_O,
    output reg         FIRST_PUMP_OUTPUT_OE_O,
    output reg         CRYSTAL_AMP_ON_O,
    // Outputs and power
    output reg         AUX_OUTPUT_ON_O,
    output reg         CLOCK_OUTPUTS_ON_O,
    output reg         POWERED_DOWN_O,
    // Second loop
    output reg         REF_DOUBLER_ON_O,
    output reg  [15:0] THIRD_POLE_OHMS_O,
    output reg  [15:0] FOURTH_POLE_OHMS_O,
    output reg  [7:0]  THIRD_POLE_PF_O,
    output reg  [7:0]  FOURTH_POLE_PF_O,
    output reg         FILTER_CODES_OK_O,
    output reg         SECOND_PUMP_OUTPUT_OE_O
);

    // ==========================================================
    // Decode helpers
    // ==========================================================
    function [15:0] res_ohms;
        input [2:0] code;
        begin
            case (code)
                3'h1:    res_ohms = `PLC_OHM_STEP;
                3'h2:    res_ohms = 16'h4E20;
                3'h3:    res_ohms = 16'h7530;
                3'h4:    res_ohms = 16'h9C40;
                default: res_ohms = 16'h0000;
            endcase
        end
    endfunction

    function [15:0] cap_pair;
        input [3:0] code;
        begin
            case (code)
                4'h0:    cap_pair = {8'h00, 8'h0A};
                4'h1:    cap_pair = {8'h00, 8'h3C};
                4'h2:    cap_pair = {8'h32, 8'h0A};
                4'h3:    cap_pair = {8'h00, 8'h6E};
                4'h4:    cap_pair = {8'h32, 8'h6E};
                4'h5:    cap_pair = {8'h64, 8'h6E};
                4'h6:    cap_pair = {8'h00, 8'hA0};
                4'h7:    cap_pair = {8'h32, 8'hA0};
                4'h8:    cap_pair = {8'h64, 8'h0A};
                4'h9:    cap_pair = {8'h64, 8'h3C};
                4'hA:    cap_pair = {8'h96, 8'h6E};
                4'hB:    cap_pair = {8'h96, 8'h3C};
                default: cap_pair = {8'h00, 8'h00};
            endcase
        end
    endfunction

    // ==========================================================
    // Register storage
    // ==========================================================
    reg  [31:0] ref_reg;
    reg  [31:0] ctrl_reg;

    always @(posedge CORE_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            ref_reg  <= `PLC_REF_RESET;
            ctrl_reg <= `PLC_CTRL_RESET;  // [R5] [R6] [R8]
        end
        else if (REG_WR_I)
        begin
            if (REG_ADDR_I == `PLC_ADDR_REF)
                ref_reg <= REG_DATA_I & `PLC_REF_MASK;
            if (REG_ADDR_I == `PLC_ADDR_CTRL)
                ctrl_reg <= REG_DATA_I & `PLC_CTRL_MASK;
        end
    end

    // ==========================================================
    // Field extraction
    // ==========================================================
    wire [11:0] ref_div   = ref_reg[`PLC_REF_DIV_LSB +: `PLC_REF_DIV_W];
    wire [2:0]  pump_code = ref_reg[`PLC_PUMP_CODE_LSB +: 3];
    wire        pdown     = ctrl_reg[`PLC_PDOWN_BIT];
    wire [2:0]  r3_code   = ctrl_reg[`PLC_R3_LSB +: 3];
    wire [2:0]  r4_code   = ctrl_reg[`PLC_R4_LSB +: 3];
    wire [3:0]  cap_code  = ctrl_reg[`PLC_CAP_LSB +: 4];
    wire [15:0] caps      = cap_pair(cap_code);

    // ==========================================================
    // Readback
    // ==========================================================
    always @(posedge CORE_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            REG_RDATA_O <= 32'h0000_0000;
        else if (REG_ADDR_I == `PLC_ADDR_REF)
            REG_RDATA_O <= ref_reg;
        else if (REG_ADDR_I == `PLC_ADDR_CTRL)
            REG_RDATA_O <= ctrl_reg;
        else
            REG_RDATA_O <= 32'h0000_0000;
    end

    // ==========================================================
    // First loop reference divider
    // ==========================================================
    reg  [11:0] div_cnt;
    wire        div_run  = (ref_div != 12'h000) && !pdown;  // [R1] [R7]
    wire        div_hit  = div_run && (div_cnt >= ref_div);

    always @(posedge CORE_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            div_cnt          <= 12'h001;
            FIRST_REF_TICK_O <= 1'b0;
        end
        else
        begin
            FIRST_REF_TICK_O <= div_hit;  // [R1]
            if (!div_run || div_hit)
                div_cnt <= 12'h001;
            else
                div_cnt <= div_cnt + 12'h001;
        end
    end

    // ==========================================================
    // Pump current decode
    // ==========================================================
    reg  [8:0] next_pump_ua;

    always @*
    begin
        case (pump_code)  // [R2]
            3'h2:    next_pump_ua = `PLC_UA_C2;
            3'h3:    next_pump_ua = `PLC_UA_C3;
            3'h4:    next_pump_ua = `PLC_UA_C4;
            3'h5:    next_pump_ua = `PLC_UA_C5;
            3'h6:    next_pump_ua = `PLC_UA_C6;
            3'h7:    next_pump_ua = `PLC_UA_C7;
            default: next_pump_ua = 9'h000;
        endcase
    end

    // ==========================================================
    // Control outputs
    // ==========================================================
    always @(posedge CORE_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            FIRST_PUMP_CURRENT_O    <= 9'h000;
            FIRST_PUMP_CODE_OK_O    <= 1'b0;
            FIRST_PUMP_POLARITY_O   <= 1'b0;
            FIRST_PUMP_OUTPUT_OE_O  <= 1'b0;
            CRYSTAL_AMP_ON_O        <= 1'b0;
            AUX_OUTPUT_ON_O         <= 1'b0;
            CLOCK_OUTPUTS_ON_O      <= 1'b0;
            POWERED_DOWN_O          <= 1'b0;
            REF_DOUBLER_ON_O        <= 1'b0;
            THIRD_POLE_OHMS_O       <= 16'h0000;
            FOURTH_POLE_OHMS_O      <= 16'h0000;
            THIRD_POLE_PF_O         <= 8'h00;
            FOURTH_POLE_PF_O        <= 8'h00;
            FILTER_CODES_OK_O       <= 1'b0;
            SECOND_PUMP_OUTPUT_OE_O <= 1'b0;
        end
        else
        begin
            POWERED_DOWN_O        <= pdown;  // [R7]
            FIRST_PUMP_CURRENT_O  <= pdown ? 9'h000 : next_pump_ua;  // [R2]
            FIRST_PUMP_CODE_OK_O  <= (pump_code[2] | pump_code[1]);  // [R2]
            FIRST_PUMP_POLARITY_O <= ref_reg[`PLC_PUMP_POL_BIT];  // [R3]
            FIRST_PUMP_OUTPUT_OE_O <=
                !ctrl_reg[`PLC_HIGHZ1_BIT] && !pdown;  // [R13] [R7]
            SECOND_PUMP_OUTPUT_OE_O <=
                !ctrl_reg[`PLC_HIGHZ2_BIT] && !pdown;  // [R14] [R7]
            CRYSTAL_AMP_ON_O <=
                ctrl_reg[`PLC_XTAL_BIT] && !pdown;  // [R4] [R7]
            AUX_OUTPUT_ON_O <=
                ctrl_reg[`PLC_AUX_BIT] && !pdown;  // [R5] [R7]
            CLOCK_OUTPUTS_ON_O <= OUTPUT_ENABLE_PIN_I
                && ctrl_reg[`PLC_GLOBAL_BIT] && !pdown;  // [R6] [R15] [R7]
            REF_DOUBLER_ON_O <=
                ctrl_reg[`PLC_DOUBLER_BIT] && !pdown;  // [R8] [R7]
            THIRD_POLE_OHMS_O  <= res_ohms(r3_code);  // [R10]
            FOURTH_POLE_OHMS_O <= res_ohms(r4_code);  // [R11]
            THIRD_POLE_PF_O    <= caps[15:8];  // [R12]
            FOURTH_POLE_PF_O   <= caps[7:0];  // [R12]
            FILTER_CODES_OK_O  <= (r3_code <= `PLC_RES_MAX_CODE)
                && (r4_code <= `PLC_RES_MAX_CODE)
                && (cap_code <= `PLC_CAP_MAX_CODE);  // [R10] [R11] [R12]
        end
    end

endmodule
`default_nettype wire

/* src/plc_map.vh */
// Register numbers, field positions and reset values of the loop
// configuration registers. Included by the configuration bank only.
`ifndef PLC_MAP_VH
`define PLC_MAP_VH

// Register numbers on the load port
`define PLC_ADDR_W          4
`define PLC_ADDR_REF        4'h0C
`define PLC_ADDR_CTRL       4'h0D

// Reference register fields
`define PLC_REF_DIV_LSB     0
`define PLC_REF_DIV_W       12
`define PLC_PUMP_CODE_LSB   12
`define PLC_PUMP_POL_BIT    15
`define PLC_REF_MASK        32'h0000_FFFF
`define PLC_REF_RESET       32'h0000_2001

// Oscillator, power and filter control register fields
`define PLC_XTAL_BIT        21
`define PLC_AUX_BIT         20
`define PLC_GLOBAL_BIT      18
`define PLC_PDOWN_BIT       17
`define PLC_DOUBLER_BIT     16
`define PLC_R3_LSB          13
`define PLC_R4_LSB          10
`define PLC_CAP_LSB         6
`define PLC_HIGHZ1_BIT      5
`define PLC_HIGHZ2_BIT      4
`define PLC_CTRL_MASK       32'h0037_FFF0
`define PLC_CTRL_RESET      32'h0004_0000

// Pump current codes, in microamps
`define PLC_UA_C2           9'h014
`define PLC_UA_C3           9'h050
`define PLC_UA_C4           9'h019
`define PLC_UA_C5           9'h032
`define PLC_UA_C6           9'h064
`define PLC_UA_C7           9'h190

// Resistor steps, in ohms, and largest legal codes
`define PLC_OHM_STEP        16'h2710
`define PLC_RES_MAX_CODE    3'h4
`define PLC_CAP_MAX_CODE    4'hB

`endif

/* tb/plc_loop_config_asserts.sv */
// Checker: port-level properties of the loop configuration bank.
// Assumes it is bound onto plc_loop_config, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module plc_loop_config_asserts
(
    // Clock, reset and load port
    input wire logic        CORE_CLK_I,
    input wire logic        NRST_I,
    input wire logic        REG_WR_I,
    input wire logic [3:0]  REG_ADDR_I,
    input wire logic [31:0] REG_DATA_I,
    input wire logic [31:0] REG_RDATA_O,
    // Pin and decoded outputs
    input wire logic        OUTPUT_ENABLE_PIN_I,
    input wire logic        FIRST_REF_TICK_O,
    input wire logic [8:0]  FIRST_PUMP_CURRENT_O,
    input wire logic        FIRST_PUMP_CODE_OK_O,
    input wire logic        FIRST_PUMP_OUTPUT_OE_O,
    input wire logic        AUX_OUTPUT_ON_O,
    input wire logic        CLOCK_OUTPUTS_ON_O,
    input wire logic        POWERED_DOWN_O,
    input wire logic [15:0] THIRD_POLE_OHMS_O,
    input wire logic [15:0] FOURTH_POLE_OHMS_O,
    input wire logic [7:0]  FOURTH_POLE_PF_O,
    input wire logic        FILTER_CODES_OK_O,
    input wire logic        SECOND_PUMP_OUTPUT_OE_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);
    a_pdown_stops:
    assert property (POWERED_DOWN_O |-> !(CLOCK_OUTPUTS_ON_O | AUX_OUTPUT_ON_O
        | FIRST_PUMP_OUTPUT_OE_O | SECOND_PUMP_OUTPUT_OE_O | FIRST_REF_TICK_O)
        && FIRST_PUMP_CURRENT_O == 9'h000) else $error("Block on in power-down");
    a_pdown_follows:
    assert property (REG_WR_I && REG_ADDR_I == 4'hD && REG_DATA_I[17]
        ##1 !REG_WR_I |=> POWERED_DOWN_O) else $error("Power-down not taken");
    a_ctrl_readback:
    assert property (REG_WR_I && REG_ADDR_I == 4'hD ##1 !REG_WR_I
        && REG_ADDR_I == 4'hD |=> REG_RDATA_O == ($past(REG_DATA_I, 2)
        & 32'h0037_FFF0)) else $error("Control readback wrong");
    a_clock_needs_pin:
    assert property (CLOCK_OUTPUTS_ON_O |-> $past(OUTPUT_ENABLE_PIN_I)
        && !POWERED_DOWN_O) else $error("Clocks on without enables");
    a_pump_code_ok:
    assert property (!POWERED_DOWN_O |-> FIRST_PUMP_CODE_OK_O ==
        (FIRST_PUMP_CURRENT_O inside {9'h014, 9'h050, 9'h019, 9'h032,
        9'h064, 9'h190})) else $error("Pump current and flag disagree");
    a_third_ohms:
    assert property (THIRD_POLE_OHMS_O inside {16'h0000, 16'h2710, 16'h4E20,
        16'h7530, 16'h9C40}) else $error("Third-pole value illegal");
    a_fourth_ohms:
    assert property (FOURTH_POLE_OHMS_O inside {16'h0000, 16'h2710, 16'h4E20,
        16'h7530, 16'h9C40}) else $error("Fourth-pole value illegal");
    a_cap_reserved:
    assert property (FOURTH_POLE_PF_O == 8'h00 |-> !FILTER_CODES_OK_O)
        else $error("Reserved capacitor code flagged valid");
endmodule
`default_nettype wire

/* tb/plc_host_model.sv */
// Host model: loads whole registers and reads them back.
// Assumes the bank samples the load port on CORE_CLK_I rising edges.
`timescale 1ns/100ps
`default_nettype none
module plc_host_model
(
    // Clock and readback
    input  wire logic        CORE_CLK_I,
    input  wire logic [31:0] REG_RDATA_O,
    // Load port
    output var  logic        REG_WR_I,
    output var  logic [3:0]  REG_ADDR_I,
    output var  logic [31:0] REG_DATA_I
);
    initial {REG_WR_I, REG_ADDR_I, REG_DATA_I} = '0;
    // Codes come from the caller; released data is inverted
    task automatic load(input logic [3:0] a, input logic [31:0] d);
        @(posedge CORE_CLK_I) #1;
        {REG_WR_I, REG_ADDR_I, REG_DATA_I} = {1'b1, a, d};
        @(posedge CORE_CLK_I) #1;
        REG_WR_I = 1'b0;
        REG_DATA_I = ~d;
        @(posedge CORE_CLK_I) #1;
    endtask
    task automatic fetch(input logic [3:0] a, output logic [31:0] d);
        @(posedge CORE_CLK_I) #1;
        REG_ADDR_I = a;
        @(posedge CORE_CLK_I);
        @(posedge CORE_CLK_I) #1;
        d = REG_RDATA_O;
    endtask
endmodule
`default_nettype wire

/* tb/plc_loop_config_test.sv */
// Testbench: register loads and decoded outputs of the bank.
// Assumes plc_loop_config and the host model compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module plc_loop_config_test;
    logic CORE_CLK_I = 1'b0, NRST_I = 1'b0, OUTPUT_ENABLE_PIN_I = 1'b1;
    logic REG_WR_I, FIRST_REF_TICK_O, FIRST_PUMP_CODE_OK_O, CRYSTAL_AMP_ON_O;
    logic FIRST_PUMP_POLARITY_O, FIRST_PUMP_OUTPUT_OE_O, AUX_OUTPUT_ON_O;
    logic CLOCK_OUTPUTS_ON_O, POWERED_DOWN_O, REF_DOUBLER_ON_O;
    logic FILTER_CODES_OK_O, SECOND_PUMP_OUTPUT_OE_O;
    logic [3:0]  REG_ADDR_I;
    logic [31:0] REG_DATA_I, REG_RDATA_O, rd;
    logic [8:0]  FIRST_PUMP_CURRENT_O;
    logic [15:0] THIRD_POLE_OHMS_O, FOURTH_POLE_OHMS_O, e, n;
    logic [7:0]  THIRD_POLE_PF_O, FOURTH_POLE_PF_O;
    logic [8:0]  ua[8] = '{0, 0, 20, 80, 25, 50, 100, 400};
    logic [7:0]  c3[16] = '{0, 0, 50, 0, 50, 100, 0, 50, 100, 100, 150, 150,
                            0, 0, 0, 0};
    logic [7:0]  c4[16] = '{10, 60, 10, 110, 110, 110, 160, 160, 10, 60, 110,
                            60, 0, 0, 0, 0};
    logic [11:0] rv[3] = '{0, 3, 4095};
    int error_cnt = 0, checks_done = 0, cycles = 0;
    plc_loop_config u_dut (.*);
    plc_host_model u_host (.*);
    always #25 CORE_CLK_I = ~CORE_CLK_I;
    task automatic complete_run;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge CORE_CLK_I)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge CORE_CLK_I);
        #1 NRST_I = 1'b1;
        u_host.fetch(4'hC, rd);
        `CHK(rd, 32'h0000_2001)
        u_host.fetch(4'hD, rd);
        `CHK(rd, 32'h0004_0000)
        `CHK({CLOCK_OUTPUTS_ON_O, AUX_OUTPUT_ON_O, REF_DOUBLER_ON_O}, 3'h4)
        for (int i = 0; i < 8; i++)
        begin
            u_host.load(4'hC, {16'h0000, i[0], 3'(i), 12'h001});
            `CHK(FIRST_PUMP_CURRENT_O, ua[i])
            `CHK(FIRST_PUMP_POLARITY_O, i[0])
            `CHK(FIRST_PUMP_CODE_OK_O, 1'(i >= 2))
        end
        foreach (rv[k])
        begin
            u_host.load(4'hC, {20'h0_0002, rv[k]});
            n = 16'h0000;
            repeat (12285) @(posedge CORE_CLK_I) #1 n += FIRST_REF_TICK_O;
            `CHK(n, 16'(rv[k] ? 12285 / rv[k] : 0))
        end
        for (int i = 0; i < 16; i++)
        begin
            u_host.load(4'hD, 32'h0004_0000 | {10'h000, i[0], i[1], 3'h0,
                i[2], 3'(i), 3'(i), 4'(i), i[0], i[1], 4'h0});
            `CHK({CRYSTAL_AMP_ON_O, AUX_OUTPUT_ON_O}, {i[0], i[1]})
            `CHK(REF_DOUBLER_ON_O, i[2])
            `CHK(FIRST_PUMP_OUTPUT_OE_O, !i[0])
            `CHK(SECOND_PUMP_OUTPUT_OE_O, !i[1])
            e = (i % 8 <= 4) ? 16'(i % 8 * 10000) : 16'h0000;
            `CHK(THIRD_POLE_OHMS_O, e)
            `CHK(FOURTH_POLE_OHMS_O, e)
            `CHK({THIRD_POLE_PF_O, FOURTH_POLE_PF_O}, {c3[i], c4[i]})
            `CHK(FILTER_CODES_OK_O, 1'(i % 8 <= 4 && i < 12))
        end
        u_host.load(4'hC, 32'h0000_2001);
        // Doubler set only for a slow second reference
        u_host.load(4'hD, 32'h0035_0000);
        `CHK(CLOCK_OUTPUTS_ON_O, 1'b1)
        OUTPUT_ENABLE_PIN_I = 1'b0;
        @(posedge CORE_CLK_I) #1;
        `CHK(CLOCK_OUTPUTS_ON_O, 1'b0)
        OUTPUT_ENABLE_PIN_I = 1'b1;
        u_host.load(4'hD, 32'h0031_0000);
        `CHK(CLOCK_OUTPUTS_ON_O, 1'b0)
        u_host.load(4'hD, 32'h0037_0000);
        `CHK({CLOCK_OUTPUTS_ON_O, AUX_OUTPUT_ON_O, FIRST_REF_TICK_O,
            FIRST_PUMP_CURRENT_O}, 12'h000)
        `CHK(POWERED_DOWN_O, 1'b1)
        `CHK({FIRST_PUMP_OUTPUT_OE_O, SECOND_PUMP_OUTPUT_OE_O}, 2'h0)
        u_host.load(4'hD, 32'h0035_0000);
        `CHK(CLOCK_OUTPUTS_ON_O, 1'b1)
        u_host.load(4'hD, 32'hFFFF_FFFF);
        u_host.load(4'hE, 32'h0000_0000);
        u_host.fetch(4'hD, rd);
        `CHK(rd, 32'h0037_FFF0)
        u_host.fetch(4'hE, rd);
        `CHK(rd, 32'h0000_0000)
        complete_run();
    end
endmodule
bind plc_loop_config plc_loop_config_asserts u_chk (.*);
`default_nettype wire
